// File: core/abs_ctrl.sv
// register file, routing switch gating and comparator logic of the amplifier block
//
// Behaviour
// - three switches route amp outputs to buses
// - route switches use channel, enable, fabric
// - mask bit zero forces route switch open
// - zero port or pin address opens switch unless fabric input high or a clear hw route enable bit closes it
// - switch one close conditions
// - switch two open and close conditions
// - switch three open and close conditions
// - switch state readable at bits 30:28
// - control bit 4 selects comparator mode
// - control bit 5 enables hysteresis
// - control bits 1:0 select power mode
// - bit 6 bypasses fabric output sync
// - bit 7 selects pulse or level
// - comparator states at status bits 0,16
// - bits 9:8 select interrupt edge
// - one flag per comparator
// - irq when flag and enable both set
// - writing one clears a flag
// - gated view is flags and enables
// - force register raises flags
// - global block enable register
// - switch bit closes, clear register opens
`timescale 1ns/1ns
module abs_ctrl (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// axi4-lite write address
	input wire logic [abs_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [abs_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [abs_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [abs_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// adc channel configuration
	input wire logic [2:0] chanPortAddr,
	input wire logic [2:0] chanPinAddr,
	input wire logic chanDiffMode,
	// fabric route controls and raw comparator outputs
	input wire logic [3:2] fabricIn,
	input wire logic [1:0] compRaw,
	// analog controls
	output logic blockEnable,
	output logic [1:0] ampPwrMode0,
	output logic [1:0] ampPwrMode1,
	output logic [1:0] comparatorModeOn,
	output logic [1:0] hysteresisOn,
	output logic [abs_pkg::DATA_W-1:0] ampSwitch0,
	output logic [abs_pkg::DATA_W-1:0] ampSwitch1,
	// route switches
	output logic routeSwitchOne,
	output logic routeSwitchTwo,
	output logic routeSwitchThree,
	// fabric triggers and interrupt
	output logic [1:0] fabricTrig,
	output logic irq
);
	import abs_pkg::*;

	logic [DATA_W-1:0] blockEnableReg;
	logic [DATA_W-1:0] ampControl [2];
	logic [DATA_W-1:0] ampSwitchCtl [2];
	logic [DATA_W-1:0] hwRouteEnable;
	logic [1:0] irqFlags;
	logic [1:0] irqEnableBits;
	logic [1:0] next_irqFlags;
	logic [ADDR_W-1:0] awAddr;
	logic awHeld;
	logic [DATA_W-1:0] wData;
	logic [3:0] wStrb;
	logic wHeld;
	logic wrGo;
	logic [DATA_W-1:0] rdMux;
	logic rdHit;
	logic wrHit;
	logic [1:0] cmpMeta;
	logic [1:0] cmpSync;
	logic [1:0] cmpPrev;
	logic [3:2] fabMeta;
	logic [3:2] fabSync;
	logic [1:0] edgeEvt;
	logic [1:0] syncTrig;
	logic [2:0] routeState;

	function automatic logic [DATA_W-1:0] merge(
		input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] nw,
		input logic [3:0] strb
	);
		logic [DATA_W-1:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	// write address and data are taken independently
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			awHeld <= 1'b0;
			awAddr <= '0;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHeld <= 1'b1;
			awAddr <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (wrGo) begin
			awHeld <= 1'b0;
			s_axi_awready <= 1'b1;
		end else if (!awHeld) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wHeld <= 1'b0;
			wData <= RST_WORD;
			wStrb <= 4'h0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHeld <= 1'b1;
			wData <= s_axi_wdata;
			wStrb <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (wrGo) begin
			wHeld <= 1'b0;
			s_axi_wready <= 1'b1;
		end else if (!wHeld) begin
			s_axi_wready <= 1'b1;
		end
	end

	assign wrGo = awHeld && wHeld && !s_axi_bvalid;

	always_comb begin
		case (awAddr)
			OFF_BLOCK_ENABLE, OFF_AMP0_CONTROL, OFF_AMP1_CONTROL, OFF_COMP_STATE,
			OFF_IRQ_FLAGS, OFF_IRQ_FORCE, OFF_IRQ_ENABLE, OFF_IRQ_GATED,
			OFF_AMP0_SWITCH, OFF_AMP0_SW_CLR, OFF_AMP1_SWITCH, OFF_AMP1_SW_CLR,
			OFF_HW_ROUTE, OFF_ROUTE_STATE: wrHit = 1'b1;
			default: wrHit = 1'b0;
		endcase
	end

	// write response, error for unmapped addresses
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wrGo) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// control registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			blockEnableReg <= RST_WORD;
			hwRouteEnable <= RST_WORD;
		end else if (wrGo) begin
			if (awAddr == OFF_BLOCK_ENABLE) begin
				blockEnableReg <= merge(blockEnableReg, wData, wStrb);
			end
			if (awAddr == OFF_HW_ROUTE) begin
				hwRouteEnable <= merge(hwRouteEnable, wData, wStrb);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ampControl[0] <= RST_WORD;
			ampControl[1] <= RST_WORD;
		end else if (wrGo) begin
			if (awAddr == OFF_AMP0_CONTROL) begin
				ampControl[0] <= merge(ampControl[0], wData, wStrb);
			end
			if (awAddr == OFF_AMP1_CONTROL) begin
				ampControl[1] <= merge(ampControl[1], wData, wStrb);
			end
		end
	end

	// switch registers: a set bit closes, a one in the clear register opens
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ampSwitchCtl[0] <= RST_WORD;
			ampSwitchCtl[1] <= RST_WORD;
		end else if (wrGo) begin
			if (awAddr == OFF_AMP0_SWITCH) begin
				ampSwitchCtl[0] <= merge(ampSwitchCtl[0], wData, wStrb);
			end
			if (awAddr == OFF_AMP0_SW_CLR) begin
				ampSwitchCtl[0] <= ampSwitchCtl[0] & ~merge(RST_WORD, wData, wStrb);
			end
			if (awAddr == OFF_AMP1_SWITCH) begin
				ampSwitchCtl[1] <= merge(ampSwitchCtl[1], wData, wStrb);
			end
			if (awAddr == OFF_AMP1_SW_CLR) begin
				ampSwitchCtl[1] <= ampSwitchCtl[1] & ~merge(RST_WORD, wData, wStrb);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irqEnableBits <= RST_FLAGS;
		end else if (wrGo && awAddr == OFF_IRQ_ENABLE && wStrb[0]) begin
			irqEnableBits <= wData[1:0];
		end
	end

	// read channel, one cycle to data
	always_comb begin
		rdHit = 1'b1;
		rdMux = RST_WORD;
		case (s_axi_araddr)
			OFF_BLOCK_ENABLE: rdMux = blockEnableReg;
			OFF_AMP0_CONTROL: rdMux = ampControl[0];
			OFF_AMP1_CONTROL: rdMux = ampControl[1];
			OFF_COMP_STATE: begin
				rdMux[0] = cmpSync[0];
				rdMux[STAT_C1] = cmpSync[1];
			end
			OFF_IRQ_FLAGS, OFF_IRQ_FORCE: rdMux[1:0] = irqFlags;
			OFF_IRQ_ENABLE: rdMux[1:0] = irqEnableBits;
			OFF_IRQ_GATED: rdMux[1:0] = irqFlags & irqEnableBits;
			OFF_AMP0_SWITCH, OFF_AMP0_SW_CLR: rdMux = ampSwitchCtl[0];
			OFF_AMP1_SWITCH, OFF_AMP1_SW_CLR: rdMux = ampSwitchCtl[1];
			OFF_HW_ROUTE: rdMux = hwRouteEnable;
			OFF_ROUTE_STATE: rdMux[ROUTE_LO +: 3] = routeState;
			default: rdHit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= RST_WORD;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdMux;
			s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	// two-stage synchronisers for comparators and fabric
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cmpMeta <= 2'h0;
			cmpSync <= 2'h0;
			cmpPrev <= 2'h0;
			fabMeta <= 2'h0;
			fabSync <= 2'h0;
		end else begin
			cmpMeta <= compRaw;
			cmpSync <= cmpMeta;
			cmpPrev <= cmpSync;
			fabMeta <= fabricIn;
			fabSync <= fabMeta;
		end
	end

	// edge detection per comparator
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			case (abs_edge_e'(ampControl[i][CTL_EDGE_LO +: 2]))
				EDGE_RISE: edgeEvt[i] = cmpSync[i] & ~cmpPrev[i];
				EDGE_FALL: edgeEvt[i] = ~cmpSync[i] & cmpPrev[i];
				EDGE_BOTH: edgeEvt[i] = cmpSync[i] ^ cmpPrev[i];
				default: edgeEvt[i] = 1'b0;
			endcase
			syncTrig[i] = ampControl[i][CTL_LVL] ? cmpSync[i]
				: (cmpSync[i] & ~cmpPrev[i]);
		end
	end

	// flags: set by edge or force, cleared by writing one; set wins
	always_comb begin
		next_irqFlags = irqFlags;
		if (wrGo && awAddr == OFF_IRQ_FLAGS && wStrb[0]) begin
			next_irqFlags = next_irqFlags & ~wData[1:0];
		end
		next_irqFlags = next_irqFlags | edgeEvt;
		if (wrGo && awAddr == OFF_IRQ_FORCE && wStrb[0]) begin
			next_irqFlags = next_irqFlags | wData[1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irqFlags <= RST_FLAGS;
			irq <= 1'b0;
		end else begin
			irqFlags <= next_irqFlags;
			irq <= |(next_irqFlags & irqEnableBits);
		end
	end

	// routing switch gating
	always_comb begin
		routeState[0] = ampSwitchCtl[0][SW_MASK_A] & (fabSync[2]
			| ~hwRouteEnable[HW_ONE]
			| (chanPortAddr == PORT_ONE && chanPinAddr == PIN_TWO));
		routeState[1] = ampSwitchCtl[1][SW_MASK_A] & (fabSync[3]
			| ~hwRouteEnable[HW_TWO]
			| (!chanDiffMode && chanPortAddr == PORT_ONE && chanPinAddr == PIN_THREE));
		routeState[2] = ampSwitchCtl[1][SW_MASK_B] & (fabSync[3]
			| ~hwRouteEnable[HW_TWO]
			| (chanDiffMode && chanPortAddr == PORT_ONE && chanPinAddr == PIN_TWO));
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			routeSwitchOne <= 1'b0;
			routeSwitchTwo <= 1'b0;
			routeSwitchThree <= 1'b0;
		end else begin
			routeSwitchOne <= routeState[0];
			routeSwitchTwo <= routeState[1];
			routeSwitchThree <= routeState[2];
		end
	end

	// analog control outputs
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			blockEnable <= 1'b0;
			ampPwrMode0 <= 2'h0;
			ampPwrMode1 <= 2'h0;
			comparatorModeOn <= 2'h0;
			hysteresisOn <= 2'h0;
			ampSwitch0 <= RST_WORD;
			ampSwitch1 <= RST_WORD;
		end else begin
			blockEnable <= blockEnableReg[EN_BIT];
			ampPwrMode0 <= ampControl[0][CTL_PWR_LO +: 2];
			ampPwrMode1 <= ampControl[1][CTL_PWR_LO +: 2];
			comparatorModeOn <= {ampControl[1][CTL_CMP], ampControl[0][CTL_CMP]};
			hysteresisOn <= {ampControl[1][CTL_HYS], ampControl[0][CTL_HYS]};
			ampSwitch0 <= ampSwitchCtl[0];
			ampSwitch1 <= ampSwitchCtl[1];
		end
	end

	// fabric trigger: synchronised pulse or level, or raw when bypassed
	logic [1:0] trigReg;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			trigReg <= 2'h0;
		end else begin
			trigReg <= syncTrig;
		end
	end

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			fabricTrig[i] = ampControl[i][CTL_BYP] ? compRaw[i] : trigReg[i];
		end
	end
endmodule : abs_ctrl

// File: inc/abs_pkg.sv
// constants of the amplifier switch and comparator control block
package abs_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// register byte addresses
	localparam logic [ADDR_W-1:0] OFF_BLOCK_ENABLE = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_AMP0_CONTROL = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_AMP1_CONTROL = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_COMP_STATE = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_IRQ_FLAGS = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_IRQ_FORCE = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_IRQ_GATED = 8'h1c;
	localparam logic [ADDR_W-1:0] OFF_AMP0_SWITCH = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_AMP0_SW_CLR = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_AMP1_SWITCH = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_AMP1_SW_CLR = 8'h2c;
	localparam logic [ADDR_W-1:0] OFF_HW_ROUTE = 8'h30;
	localparam logic [ADDR_W-1:0] OFF_ROUTE_STATE = 8'h34;
	// amplifier control fields
	localparam int CTL_PWR_LO = 0;
	localparam int CTL_CMP = 4;
	localparam int CTL_HYS = 5;
	localparam int CTL_BYP = 6;
	localparam int CTL_LVL = 7;
	localparam int CTL_EDGE_LO = 8;
	localparam int EN_BIT = 31;
	// switch register mask bits
	localparam int SW_MASK_A = 18;
	localparam int SW_MASK_B = 19;
	// hardware route enable bits
	localparam int HW_ONE = 2;
	localparam int HW_TWO = 3;
	// status positions
	localparam int STAT_C1 = 16;
	localparam int ROUTE_LO = 28;
	// channel address matches
	localparam logic [2:0] PORT_ONE = 3'h1;
	localparam logic [2:0] PIN_TWO = 3'h2;
	localparam logic [2:0] PIN_THREE = 3'h3;
	// reset values
	localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
	localparam logic [1:0] RST_FLAGS = 2'h0;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// edge select encoding
	typedef enum logic [1:0] {
		EDGE_OFF = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_FALL = 2'b10,
		EDGE_BOTH = 2'b11
	} abs_edge_e;
endpackage : abs_pkg

// File: dv/abs_far_side.sv
// behavioural adc sequencer, fabric and comparator source
`timescale 1ns/1ns
module abs_far_side (
	// stimulus from the bench
	input wire logic clk_sys,
	input wire logic [2:0] wantPort,
	input wire logic [2:0] wantPin,
	input wire logic wantDiff,
	input wire logic [1:0] wantFab,
	input wire logic [1:0] wantComp,
	// levels seen by the block
	output logic [2:0] chanPortAddr = 3'h0,
	output logic [2:0] chanPinAddr = 3'h0,
	output logic chanDiffMode = 1'h0,
	output logic [3:2] fabricIn = 2'h0,
	output logic [1:0] compRaw = 2'h0
);
	// one sequencer step per clock
	always @(posedge clk_sys) begin
		chanPortAddr <= wantPort;
		chanPinAddr <= wantPin;
		chanDiffMode <= wantDiff;
		fabricIn <= wantFab;
		compRaw <= wantComp;
	end
endmodule : abs_far_side

// File: dv/abs_ctrl_chk.sv
// assertions on the ports of the amplifier switch block
`timescale 1ns/1ns
module abs_ctrl_chk (
	// clock, reset and register writes
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [abs_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [abs_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	// channel fields and controls
	input wire logic [2:0] chanPortAddr,
	input wire logic [2:0] chanPinAddr,
	input wire logic chanDiffMode,
	input wire logic blockEnable,
	input wire logic [1:0] ampPwrMode0,
	input wire logic [1:0] comparatorModeOn,
	input wire logic [1:0] hysteresisOn,
	input wire logic [abs_pkg::DATA_W-1:0] ampSwitch0,
	input wire logic [abs_pkg::DATA_W-1:0] ampSwitch1,
	input wire logic routeSwitchOne,
	input wire logic routeSwitchTwo,
	input wire logic routeSwitchThree
);
	import abs_pkg::*;
	logic [ADDR_W-1:0] wrAddr;
	logic [DATA_W-1:0] wrData;
	// remember the write in flight
	always_ff @(posedge clk_sys) begin
		if (s_axi_awvalid && s_axi_awready) wrAddr <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) wrData <= s_axi_wdata;
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// switch copies and route outputs come from the same register state
	property p_mask_one;
		!ampSwitch0[SW_MASK_A] |-> !routeSwitchOne;
	endproperty
	a_mask_one: assert property (p_mask_one) else $error("switch one not masked");
	property p_mask_amp1;
		(!ampSwitch1[SW_MASK_A] |-> !routeSwitchTwo)
			and (!ampSwitch1[SW_MASK_B] |-> !routeSwitchThree);
	endproperty
	a_mask_amp1: assert property (p_mask_amp1) else $error("amp1 switch not masked");
	property p_one;
		ampSwitch0[SW_MASK_A] && $past(chanPortAddr) == PORT_ONE
			&& $past(chanPinAddr) == PIN_TWO |-> routeSwitchOne;
	endproperty
	a_one: assert property (p_one) else $error("switch one open");
	property p_two;
		ampSwitch1[SW_MASK_A] && !$past(chanDiffMode) && $past(chanPortAddr) == PORT_ONE
			&& $past(chanPinAddr) == PIN_THREE |-> routeSwitchTwo;
	endproperty
	a_two: assert property (p_two) else $error("switch two open");
	property p_three;
		ampSwitch1[SW_MASK_B] && $past(chanDiffMode) && $past(chanPortAddr) == PORT_ONE
			&& $past(chanPinAddr) == PIN_TWO |-> routeSwitchThree;
	endproperty
	a_three: assert property (p_three) else $error("switch three open");
	// control outputs follow the register one cycle after the write lands
	property p_enable;
		$rose(s_axi_bvalid) && wrAddr == OFF_BLOCK_ENABLE
			|=> blockEnable == $past(wrData[EN_BIT]);
	endproperty
	a_enable: assert property (p_enable) else $error("block enable wrong");
	property p_control;
		$rose(s_axi_bvalid) && wrAddr == OFF_AMP0_CONTROL |=> ampPwrMode0 == $past(wrData[1:0])
			&& comparatorModeOn[0] == $past(wrData[CTL_CMP])
			&& hysteresisOn[0] == $past(wrData[CTL_HYS]);
	endproperty
	a_control: assert property (p_control) else $error("amp0 control wrong");
	property p_clear;
		$rose(s_axi_bvalid) && wrAddr == OFF_AMP0_SW_CLR |=> (ampSwitch0 & $past(wrData)) == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("switch not cleared");
endmodule : abs_ctrl_chk
bind abs_ctrl abs_ctrl_chk abs_ctrl_chk_inst (.*);

// File: dv/abs_ctrl_test.sv
// self-checking bench of the amplifier switch block
`timescale 1ns/1ns
module abs_ctrl_test;
	import abs_pkg::*;
	logic clk_sys, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, ampSwitch0, ampSwitch1, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, ampPwrMode0, ampPwrMode1, comparatorModeOn;
	logic [1:0] hysteresisOn, fabricTrig, compRaw, wantFab, wantComp, rsp;
	logic routeSwitchOne, routeSwitchTwo, routeSwitchThree, chanDiffMode, wantDiff;
	logic blockEnable, irq;
	logic [2:0] chanPortAddr, chanPinAddr, wantPort, wantPin, rs, ex;
	logic [3:2] fabricIn;
	int errTotal, cmpCount;
	assign rs = {routeSwitchThree, routeSwitchTwo, routeSwitchOne};
	abs_ctrl abs_ctrl_inst (.*);
	abs_far_side abs_far_side_inst (.*);
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			errTotal++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d mismatches %0d", cmpCount, errTotal);
		if (errTotal == 0 && cmpCount > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	task automatic hang(input int n);
		if (n > 60) begin
			errTotal++;
			test_done();
		end
	endtask : hang
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		n = 0;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			n++;
			hang(n);
		end while (s_axi_bvalid !== 1'h1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : wr
	task automatic rdw(input logic [7:0] a);
		int n;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		n = 0;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			n++;
			hang(n);
		end while (s_axi_rvalid !== 1'h1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : rdw
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rdw(a);
		chk($sformatf("reg %h", a), rd, e);
		chk("read resp", {30'h0, rsp}, {30'h0, RESP_OKAY});
	endtask : rc
	// expected route switches for one table case
	function automatic logic [2:0] rte(input logic m, input int i);
		logic [2:0] po, pi;
		po = {2'h0, i[0]};
		pi = i[1] ? PIN_THREE : {1'h0, i[0], 1'h0};
		rte[0] = m & (i[5] | !i[3] | (po == PORT_ONE && pi == PIN_TWO));
		rte[1] = m & (i[6] | !i[4] | (!i[2] && po == PORT_ONE && pi == PIN_THREE));
		rte[2] = m & (i[6] | !i[4] | (i[2] && po == PORT_ONE && pi == PIN_TWO));
	endfunction : rte
	initial begin
		clk_sys = 1'h0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial begin
		rst = 1'h1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{wantPort, wantPin, wantDiff, wantFab, wantComp} = '0;
		s_axi_wstrb = 4'hf;
		errTotal = 0;
		cmpCount = 0;
		tick(20);
		rst <= 1'h0;
		for (int a = 0; a <= 'h34; a += 4) rc(8'(a), RST_WORD);
		rdw(8'h40);
		chk("bad read", rd, 32'h0);
		chk("bad read resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
		wr(8'h40, 32'hffff_ffff);
		chk("bad write resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
		wr(OFF_COMP_STATE, 32'hffff_ffff);
		rc(OFF_COMP_STATE, 32'h0);
		wr(OFF_BLOCK_ENABLE, 32'h8000_0000);
		tick(1);
		chk("enable", {31'h0, blockEnable}, 32'h1);
		for (int p = 1; p < 4; p++) begin
			wr(OFF_AMP1_CONTROL, 32'h30 | p);
			tick(1);
			chk("amp1", {hysteresisOn[1], comparatorModeOn[1], ampPwrMode1}, 4'hc | p);
		end
		wr(OFF_AMP0_SWITCH, 32'h0004_0011);
		wr(OFF_AMP0_SW_CLR, 32'h0000_0010);
		rc(OFF_AMP0_SWITCH, 32'h0004_0001);
		$display("test registers done");
		for (int m = 0; m < 2; m++) begin
			wr(OFF_AMP0_SWITCH, m ? 32'h0004_0000 : 32'h0);
			wr(OFF_AMP1_SWITCH, m ? 32'h000c_0000 : 32'h0);
			for (int i = 0; i < 128; i++) begin
				wr(OFF_HW_ROUTE, {28'h0, 2'(i >> 3), 2'h0});
				wantPort <= {2'h0, i[0]};
				wantPin <= i[1] ? PIN_THREE : {1'h0, i[0], 1'h0};
				wantDiff <= i[2];
				wantFab <= 2'(i >> 5);
				tick(6);
				ex = rte(m[0], i);
				chk("route", {29'h0, rs}, {29'h0, ex});
				rc(OFF_ROUTE_STATE, {1'h0, ex, 28'h0});
			end
		end
		chk("sw1", ampSwitch1, 32'h000c_0000);
		wr(OFF_AMP1_SW_CLR, 32'h0008_0000);
		rc(OFF_AMP1_SWITCH, 32'h0004_0000);
		chk("sw1 clr", ampSwitch1, 32'h0004_0000);
		$display("test routing done");
		wr(OFF_IRQ_ENABLE, 32'h3);
		for (int e = 0; e < 4; e++) begin
			wr(OFF_AMP0_CONTROL, 32'(e) << 8);
			wr(OFF_AMP1_CONTROL, 32'(e) << 8);
			wantComp <= 2'h3;
			tick(6);
			rc(OFF_COMP_STATE, 32'h0001_0001);
			rc(OFF_IRQ_FLAGS, {30'h0, {2{e[0]}}});
			chk("irq", {31'h0, irq}, 32'(e[0]));
			wr(OFF_IRQ_FLAGS, 32'h1);
			rc(OFF_IRQ_FLAGS, {30'h0, e[0], 1'h0});
			wr(OFF_IRQ_FLAGS, 32'h3);
			wantComp <= 2'h0;
			tick(6);
			rc(OFF_IRQ_FLAGS, {30'h0, {2{e[1]}}});
			wr(OFF_IRQ_FLAGS, 32'h3);
		end
		wr(OFF_IRQ_FORCE, 32'h2);
		rc(OFF_IRQ_FLAGS, 32'h2);
		wr(OFF_IRQ_ENABLE, 32'h1);
		rc(OFF_IRQ_GATED, 32'h0);
		chk("irq off", {31'h0, irq}, 32'h0);
		wr(OFF_IRQ_ENABLE, 32'h3);
		rc(OFF_IRQ_GATED, 32'h2);
		chk("irq on", {31'h0, irq}, 32'h1);
		$display("test interrupts done");
		// model edge, two sync stages, then the trigger flop
		wantComp <= 2'h1;
		tick(5);
		chk("pulse", {30'h0, fabricTrig}, 32'h1);
		tick(1);
		chk("pulse end", {30'h0, fabricTrig}, 32'h0);
		wr(OFF_AMP0_CONTROL, 32'h80);
		tick(1);
		chk("level", {30'h0, fabricTrig}, 32'h1);
		wr(OFF_AMP0_CONTROL, 32'h40);
		tick(1);
		chk("bypass high", {30'h0, fabricTrig}, 32'h1);
		wantComp <= 2'h0;
		tick(2);
		chk("bypass", {30'h0, fabricTrig}, 32'h0);
		$display("test triggers done");
		test_done();
	end
endmodule : abs_ctrl_test
